//--- common/tmr0_pkg.sv
/*
 * tmr0_pkg: register map, field positions, reset values, mode and clock
 * select encodings for the 8-bit timer/counter.
 * assumes a byte-wide register port with a 6-bit address.
 */
`default_nettype none

package tmr0_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [5:0] CMP_B_OFS   = 6'h28;
   localparam logic [5:0] CMP_A_OFS   = 6'h29;
   localparam logic [5:0] CTRL_A_OFS  = 6'h2a;
   localparam logic [5:0] CNT_OFS     = 6'h32;
   localparam logic [5:0] CTRL_B_OFS  = 6'h33;
   localparam logic [5:0] FLAGS_OFS   = 6'h38;
   localparam logic [5:0] MASK_OFS    = 6'h39;
   localparam logic [5:0] FCLR_OFS    = 6'h3a;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int FORCE_A_BIT = 7;
   localparam int FORCE_B_BIT = 6;
   localparam int WAVE_HI_BIT = 3;
   localparam int OMODE_A_LSB = 6;
   localparam int OMODE_B_LSB = 4;
   localparam int CMP_A_BIT   = 4;
   localparam int CMP_B_BIT   = 3;
   localparam int OVF_BIT     = 1;

   // ------------------------------------------------------------------
   // values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_VAL   = 8'h00;
   localparam logic [7:0] MAX_VAL   = 8'hff;
   localparam logic [7:0] BOT_VAL   = 8'h00;
   localparam int         PRE_W     = 10;
   localparam logic [9:0] DIV8_MSK  = 10'h007;
   localparam logic [9:0] DIV64_MSK = 10'h03f;
   localparam logic [9:0] DIV256_MSK = 10'h0ff;
   localparam logic [9:0] DIV1K_MSK = 10'h3ff;

   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
      CS_DIV256, CS_DIV1K, CS_EXT_FALL, CS_EXT_RISE
   } tmr0_cs_t;

   // output mode codes
   localparam logic [1:0] OM_OFF    = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR  = 2'h2;
   localparam logic [1:0] OM_SET    = 2'h3;
endpackage : tmr0_pkg

`default_nettype wire

//--- src/tmr0_core.sv
/*
 * tmr0_core: 8-bit timer/counter with clock select, compare channels,
 * waveform outputs and interrupt flags, behind a byte register port.
 * assumes one 10 MHz clock, a synchronous active-low reset and a master
 * that never issues read and write strobes together.
 */
// Overview of operation
// R1: force strobes act only in non-PWM modes; ignored in PWM modes.
// R2: force strobe makes an immediate compare event per the channel output mode.
// R3: forced events set no flag and never clear the counter.
// R4: force bits are write-only and read back zero.
// R5: software writes force bits as zero while in a PWM mode.
// R6: select 0 stops, 1 undivided, 2..5 divide by 8, 64, 256, 1024.
// R7: select 6 counts falling, 7 rising edges of the external count input.
// R8: external input counts regardless of pin direction.
// R9: counter value is readable and writable by software.
// R10: a counter write blocks the compare match on the next timer tick.
// R11: both compare values are compared continuously with the counter.
// R12: compare flags set on match of their compare value.
// R13: overflow flag set on overflow, point depends on waveform mode.
// R14: flags clear on vector taken or on writing one.
// R15: interrupt requested only with enable, global enable and flag set.
// R16: reserved bits of mask and flag registers read zero.
// R17: overflow at 0xff in normal, CLEAR_ON_MATCH_MODE, fixed fast PWM; bottom or top otherwise.
// R18: high mode bit joins the two low bits to pick the waveform mode.
// R19: counter steps by one per selected tick, holds when stopped.
`timescale 1ns/10ps
`default_nettype none

module tmr0_core
   import tmr0_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input  wire logic              clk_sys_i,
   input  wire logic              reset_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [7:0]        rdata_o,
   input  wire logic              ext_count_in_i,
   input  wire logic              global_irq_en_i,
   input  wire logic              ack_cmp_a_i,
   input  wire logic              ack_cmp_b_i,
   input  wire logic              ack_ovf_i,
   output logic                   wave_out_a_o,
   output logic                   wave_oe_a_o,
   output logic                   wave_out_b_o,
   output logic                   wave_oe_b_o,
   output logic                   irq_cmp_a_o,
   output logic                   irq_cmp_b_o,
   output logic                   irq_ovf_o,
   output logic                   irq_o
);
   import tmr0_pkg::*;

   if (ADDR_W < 6) begin : g_chk
      $error("tmr0_core: ADDR_W must be at least 6");
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0]       cnt_ff;
   logic [7:0]       cmp_a_ff;
   logic [7:0]       cmp_b_ff;
   logic [1:0]       omode_a_ff;
   logic [1:0]       omode_b_ff;
   logic [1:0]       wave_lo_ff;
   logic             wave_hi_ff;
   tmr0_cs_t         cs_ff;
   logic [2:0]       flag_ff;
   logic [2:0]       mask_ff;
   logic             block_ff;
   logic             down_ff;
   logic [PRE_W-1:0] pre_ff;
   logic [2:0]       ext_sync_ff;

   logic       sel;
   logic       wr_cnt;
   logic       wr_ctrl_b;
   logic [2:0] wave_mode;
   logic       mode_pwm;
   logic       mode_phase;
   logic       mode_fast;
   logic [7:0] top;
   logic       tick;
   logic       match_a;
   logic       match_b;
   logic       at_top;
   logic       ovf_ev;
   logic       force_a;
   logic       force_b;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [7:0] nxt_cnt;
   logic       nxt_down;
   logic [7:0] nxt_rdata;

   // address bits above the six decoded ones must be zero to hit;
   // split so the minimum width never forms a reversed part-select
   if (ADDR_W > 6) begin : g_sel_hi
      assign sel = (addr_i[ADDR_W-1:6] == '0);
   end else begin : g_sel_lo
      assign sel = 1'b1;
   end
   assign wr_cnt    = wr_i && sel && (addr_i[5:0] == CNT_OFS);
   assign wr_ctrl_b = wr_i && sel && (addr_i[5:0] == CTRL_B_OFS);

   // ------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------
   assign wave_mode  = {wave_hi_ff, wave_lo_ff};   // [R18]
   assign mode_phase = (wave_lo_ff == 2'h1);
   assign mode_fast  = (wave_lo_ff == 2'h3);
   assign mode_pwm   = mode_phase || mode_fast;
   // ocr a serves as top in ctc, phase-correct 5 and fast 7
   assign top = ((wave_mode == 3'h2) || (wave_mode == 3'h5) || (wave_mode == 3'h7))
                ? cmp_a_ff : MAX_VAL;

   // ------------------------------------------------------------------
   // clock source
   // ------------------------------------------------------------------
   // prescaler is free running, so the first prescaled tick after enable
   // can come anywhere from 1 to N cycles later
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + 1'b1;
      end
   end

   // two flops before anything looks at the pin, third for edge detect;
   // pin direction is not consulted, so driving it still counts [R8]
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ext_sync_ff <= 3'h0;
      end else begin
         ext_sync_ff <= {ext_sync_ff[1:0], ext_count_in_i};
      end
   end

   always_comb begin
      case (cs_ff)   // [R6] [R7]
         CS_STOP:     tick = 1'b0;
         CS_DIV1:     tick = 1'b1;
         CS_DIV8:     tick = ((pre_ff & DIV8_MSK) == DIV8_MSK);
         CS_DIV64:    tick = ((pre_ff & DIV64_MSK) == DIV64_MSK);
         CS_DIV256:   tick = ((pre_ff & DIV256_MSK) == DIV256_MSK);
         CS_DIV1K:    tick = ((pre_ff & DIV1K_MSK) == DIV1K_MSK);
         CS_EXT_FALL: tick = ext_sync_ff[2] && !ext_sync_ff[1];
         CS_EXT_RISE: tick = !ext_sync_ff[2] && ext_sync_ff[1];
         default:     tick = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // compare and counting
   // ------------------------------------------------------------------
   // match is judged on the tick that leaves the matching value
   assign match_a = tick && !block_ff && (cnt_ff == cmp_a_ff);   // [R10] [R11]
   assign match_b = tick && !block_ff && (cnt_ff == cmp_b_ff);   // [R10] [R11]
   assign at_top  = (cnt_ff == top);

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_down = down_ff;
      ovf_ev   = 1'b0;
      if (tick) begin   // [R19]
         if (mode_phase) begin
            if (!down_ff && at_top) begin
               nxt_down = 1'b1;
               nxt_cnt  = cnt_ff - 1'b1;
            end else if (down_ff && (cnt_ff == BOT_VAL)) begin
               nxt_down = 1'b0;
               nxt_cnt  = cnt_ff + 1'b1;
               ovf_ev   = 1'b1;   // [R13] [R17]
            end else begin
               nxt_cnt = down_ff ? cnt_ff - 1'b1 : cnt_ff + 1'b1;
            end
         end else if (mode_fast) begin
            nxt_cnt = at_top ? BOT_VAL : cnt_ff + 1'b1;
            ovf_ev  = at_top;   // [R13] [R17]
         end else begin
            // ctc clears on any tick at top, even a blocked match, never on a forced one [R3]
            nxt_cnt = (wave_mode == 3'h2 && at_top) ? BOT_VAL : cnt_ff + 1'b1;
            ovf_ev  = (cnt_ff == MAX_VAL);   // [R13] [R17]
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cnt_ff  <= RST_VAL;
         down_ff <= 1'b0;
      end else if (wr_cnt) begin
         cnt_ff <= wdata_i;   // [R9]
      end else begin
         cnt_ff  <= nxt_cnt;
         down_ff <= mode_phase ? nxt_down : 1'b0;
      end
   end

   // a write arms the block, the next timer tick consumes it
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         block_ff <= 1'b0;
      end else if (wr_cnt) begin
         block_ff <= 1'b1;   // [R10]
      end else if (tick) begin
         block_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cmp_a_ff   <= RST_VAL;
         cmp_b_ff   <= RST_VAL;
         omode_a_ff <= OM_OFF;
         omode_b_ff <= OM_OFF;
         wave_lo_ff <= 2'h0;
         wave_hi_ff <= 1'b0;
         cs_ff      <= CS_STOP;
         mask_ff    <= 3'h0;
      end else if (wr_i && sel) begin
         case (addr_i[5:0])
            CMP_A_OFS: cmp_a_ff <= wdata_i;
            CMP_B_OFS: cmp_b_ff <= wdata_i;
            CTRL_A_OFS: begin
               omode_a_ff <= wdata_i[OMODE_A_LSB+:2];
               omode_b_ff <= wdata_i[OMODE_B_LSB+:2];
               wave_lo_ff <= wdata_i[1:0];
            end
            CTRL_B_OFS: begin
               wave_hi_ff <= wdata_i[WAVE_HI_BIT];
               cs_ff      <= tmr0_cs_t'(wdata_i[2:0]);
            end
            MASK_OFS: begin
               mask_ff <= {wdata_i[CMP_A_BIT], wdata_i[CMP_B_BIT], wdata_i[OVF_BIT]};
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // waveform outputs
   // ------------------------------------------------------------------
   // software is expected to keep the force bits zero in pwm modes [R5]
   assign force_a = wr_ctrl_b && wdata_i[FORCE_A_BIT] && !mode_pwm;   // [R1]
   assign force_b = wr_ctrl_b && wdata_i[FORCE_B_BIT] && !mode_pwm;   // [R1]

   // channel b passes tog_ok low: its toggle code is reserved in pwm modes
   function automatic logic wave_next(input logic cur, input logic [1:0] om,
                                      input logic hit, input logic bump,
                                      input logic down, input logic tog_ok);
      logic v;
      v = cur;
      if (!mode_pwm) begin
         if (hit) begin
            case (om)
               OM_TOGGLE: v = !cur;
               OM_CLEAR:  v = 1'b0;
               OM_SET:    v = 1'b1;
               default:   v = cur;
            endcase
         end
      end else if (om == OM_TOGGLE) begin
         if (hit && tog_ok && wave_hi_ff) begin
            v = !cur;
         end
      end else if (om[1]) begin
         // fast pwm: set or clear at top wins over a match at top
         if (mode_fast && bump) begin
            v = !om[0];
         end else if (hit) begin
            v = om[0] ^ down;
         end
      end
      return v;
   endfunction : wave_next

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         wave_out_a_o <= 1'b0;
         wave_out_b_o <= 1'b0;
         wave_oe_a_o  <= 1'b0;
         wave_oe_b_o  <= 1'b0;
      end else begin
         // forced event drives the same path as a real match [R2]
         wave_out_a_o <= wave_next(wave_out_a_o, omode_a_ff, match_a || force_a,
                                   tick && at_top, down_ff, 1'b1);
         wave_out_b_o <= wave_next(wave_out_b_o, omode_b_ff, match_b || force_b,
                                   tick && at_top, down_ff, 1'b0);
         wave_oe_a_o  <= (omode_a_ff != OM_OFF);
         wave_oe_b_o  <= (omode_b_ff != OM_OFF);
      end
   end

   // ------------------------------------------------------------------
   // flags and interrupts
   // ------------------------------------------------------------------
   // only real matches set compare flags; forced strobes never reach here [R3]
   assign flag_set = {match_a, match_b, ovf_ev};   // [R12] [R13]
   always_comb begin
      flag_clr = {ack_cmp_a_i, ack_cmp_b_i, ack_ovf_i};   // [R14]
      if (wr_i && sel && ((addr_i[5:0] == FLAGS_OFS) || (addr_i[5:0] == FCLR_OFS))) begin
         flag_clr = flag_clr |
                    {wdata_i[CMP_A_BIT], wdata_i[CMP_B_BIT], wdata_i[OVF_BIT]};   // [R14]
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         flag_ff <= 3'h0;
      end else begin
         flag_ff <= (flag_ff & ~flag_clr) | flag_set;   // [R14]
      end
   end

   // one cycle later than the flag, but glitch free from a flop
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         irq_cmp_a_o <= 1'b0;
         irq_cmp_b_o <= 1'b0;
         irq_ovf_o   <= 1'b0;
         irq_o       <= 1'b0;
      end else begin
         irq_cmp_a_o <= global_irq_en_i && mask_ff[2] && flag_ff[2];   // [R15]
         irq_cmp_b_o <= global_irq_en_i && mask_ff[1] && flag_ff[1];   // [R15]
         irq_ovf_o   <= global_irq_en_i && mask_ff[0] && flag_ff[0];   // [R15]
         irq_o       <= global_irq_en_i && |(mask_ff & flag_ff);       // [R15]
      end
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   always_comb begin
      nxt_rdata = 8'h00;
      if (sel) begin
         case (addr_i[5:0])
            CNT_OFS:    nxt_rdata = cnt_ff;   // [R9]
            CMP_A_OFS:  nxt_rdata = cmp_a_ff;
            CMP_B_OFS:  nxt_rdata = cmp_b_ff;
            CTRL_A_OFS: nxt_rdata = {omode_a_ff, omode_b_ff, 2'h0, wave_lo_ff};
            // force bits and reserved bits read zero [R4]
            CTRL_B_OFS: nxt_rdata = {4'h0, wave_hi_ff, cs_ff};
            FLAGS_OFS:  nxt_rdata = {3'h0, flag_ff[2], flag_ff[1], 1'b0, flag_ff[0], 1'b0};  // [R16]
            MASK_OFS:   nxt_rdata = {3'h0, mask_ff[2], mask_ff[1], 1'b0, mask_ff[0], 1'b0};  // [R16]
            default:    nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= nxt_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule : tmr0_core

`default_nettype wire

//--- testbench/tmr0_props.sv
/* tmr0_props: port assertions for tmr0_core.
   assumes one clock and a master that never overlaps strobes. */
`timescale 1ns/10ps
`default_nettype none
module tmr0_props
   import tmr0_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input wire logic              clk_sys_i,
   input wire logic              reset_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0]        wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [7:0]        rdata_o,
   input wire logic              global_irq_en_i,
   input wire logic              ack_cmp_a_i,
   input wire logic              wave_out_a_o,
   input wire logic              irq_cmp_a_o,
   input wire logic              irq_cmp_b_o,
   input wire logic              irq_ovf_o,
   input wire logic              irq_o
);
   logic [7:0] ca_ff;
   logic [7:0] msk_ff;
   logic [2:0] cs_ff;
   logic       a_cb;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   assign a_cb = addr_i == ADDR_W'(CTRL_B_OFS);
   // shadows of mode, select and mask
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ca_ff  <= 8'h00;
         msk_ff <= 8'h00;
         cs_ff  <= 3'h0;
      end else if (wr_i) begin
         if (addr_i == ADDR_W'(CTRL_A_OFS)) ca_ff <= wdata_i;
         if (addr_i == ADDR_W'(MASK_OFS)) msk_ff <= wdata_i;
         if (a_cb) cs_ff <= wdata_i[2:0];
      end
   end
   // --------------------------------------------
   // force strobes, counter stopped so no real match interferes
   // --------------------------------------------
   sequence force_a_s;
      wr_i && a_cb && wdata_i[FORCE_A_BIT] && wdata_i[2:0] == 3'h0 && cs_ff == 3'h0;
   endsequence
   force_tog_a: assert property (
      force_a_s ##0 (!ca_ff[0] && ca_ff[7:6] == OM_TOGGLE)
      |=> wave_out_a_o != $past(wave_out_a_o)) else $error("forced toggle missing");
   force_pwm_a: assert property (
      force_a_s ##0 ca_ff[0] |=> $stable(wave_out_a_o)) else $error("force acted in pwm");
   force_irq_a: assert property (
      force_a_s |=> (!$rose(irq_cmp_a_o))[*3]) else $error("force raised irq");
   rd_idle_a: assert property (
      !rd_i |=> rdata_o == 8'h00) else $error("read data without read");
   rd_force_a: assert property (
      rd_i && a_cb |=> rdata_o[7:4] == 4'h0) else $error("force bits read back");
   rd_resv_a: assert property (
      rd_i && (addr_i == ADDR_W'(FLAGS_OFS) || addr_i == ADDR_W'(MASK_OFS))
      |=> (rdata_o & 8'he5) == 8'h00) else $error("reserved bits nonzero");
   gie_off_a: assert property (
      !global_irq_en_i |=> !(irq_o || irq_cmp_a_o || irq_cmp_b_o || irq_ovf_o))
      else $error("irq without global enable");
   mask_off_a: assert property (
      !msk_ff[CMP_A_BIT] |=> !irq_cmp_a_o) else $error("masked irq raised");
   irq_or_a: assert property (
      irq_o == (irq_cmp_a_o || irq_cmp_b_o || irq_ovf_o)) else $error("irq sum wrong");
   ack_clr_a: assert property (
      ack_cmp_a_i && cs_ff == 3'h0 && !wr_i |=> ##1 !irq_cmp_a_o)
      else $error("ack left flag set");
endmodule : tmr0_props

bind tmr0_core tmr0_props #(.ADDR_W(ADDR_W)) tmr0_props_i (
   .clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .global_irq_en_i,
   .ack_cmp_a_i, .wave_out_a_o, .irq_cmp_a_o, .irq_cmp_b_o, .irq_ovf_o, .irq_o
);
`default_nettype wire

//--- testbench/tmr0_pin_model.sv
/* tmr0_pin_model: far side driving the external count input.
   assumes a one-cycle go pulse loading a toggle count. */
`timescale 1ns/10ps
`default_nettype none
module tmr0_pin_model (
   input  wire logic       clk_sys_i,
   input  wire logic       go_i,
   input  wire logic [4:0] toggles_i,
   output logic            pin_o,
   output logic            done_o
);
   logic [4:0] left_ff = 5'h00;
   logic [1:0] gap_ff  = 2'h0;
   logic       pin_ff  = 1'b0;
   assign pin_o = pin_ff;
   // three-cycle half period keeps each level above one sample
   always @(posedge clk_sys_i) begin
      if (go_i) begin
         left_ff <= toggles_i;
         gap_ff  <= 2'h0;
      end else if (left_ff != 5'h00) begin
         if (gap_ff == 2'h2) begin
            pin_ff  <= !pin_ff;
            left_ff <= left_ff - 5'h01;
            gap_ff  <= 2'h0;
         end else begin
            gap_ff <= gap_ff + 2'h1;
         end
      end
   end
   assign done_o = left_ff == 5'h00;
endmodule : tmr0_pin_model
`default_nettype wire

//--- testbench/tb.sv
/* tb: self-checking bench for tmr0_core and the count pin model.
   assumes a 10 MHz clock and the register map of tmr0_pkg. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import tmr0_pkg::*;
   logic       clk_sys_i, reset_n_i, wr_i, rd_i, ext_count_in_i, global_irq_en_i;
   logic       ack_cmp_a_i, ack_cmp_b_i, ack_ovf_i, wave_out_a_o, wave_oe_a_o;
   logic       wave_out_b_o, wave_oe_b_o, irq_cmp_a_o, irq_cmp_b_o, irq_ovf_o, irq_o;
   logic       go, done;
   logic [5:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   logic [4:0] tg;
   int         mismatches, compares;
   tmr0_core tmr0_core_i (
      .clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ext_count_in_i,
      .global_irq_en_i, .ack_cmp_a_i, .ack_cmp_b_i, .ack_ovf_i, .wave_out_a_o, .wave_oe_a_o,
      .wave_out_b_o, .wave_oe_b_o, .irq_cmp_a_o, .irq_cmp_b_o, .irq_ovf_o, .irq_o
   );
   // pin acts as an output yet still counts
   tmr0_pin_model tmr0_pin_model_i (
      .clk_sys_i, .go_i(go), .toggles_i(tg), .pin_o(ext_count_in_i), .done_o(done)
   );
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // --------------------------------------------
   // bus and check helpers
   // --------------------------------------------
   task automatic close_out;
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : wt
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rc(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      chk(rdata_o, exp);
   endtask : rc
   task automatic pins(input logic [7:0] exp);
      @(negedge clk_sys_i);
      chk({4'h0, irq_cmp_a_o, irq_cmp_b_o, irq_ovf_o, irq_o}, exp);
   endtask : pins
   task automatic pulse(input int which);
      @(posedge clk_sys_i);
      ack_cmp_a_i <= which == 0;
      ack_cmp_b_i <= which == 2;
      ack_ovf_i   <= which == 1;
      @(posedge clk_sys_i);
      ack_cmp_a_i <= 1'b0;
      ack_cmp_b_i <= 1'b0;
      ack_ovf_i   <= 1'b0;
   endtask : pulse
   // --------------------------------------------
   // scenarios
   // --------------------------------------------
   task automatic t_reset;
      rc(CNT_OFS, 8'h00);
      rc(CTRL_B_OFS, 8'h00);
      rc(FLAGS_OFS, 8'h00);
      rc(6'h10, 8'h00);
      wr(MASK_OFS, 8'hff);
      rc(MASK_OFS, 8'h1a);
      wr(CNT_OFS, 8'h5a);
      wt(20);
      rc(CNT_OFS, 8'h5a);
   endtask : t_reset
   task automatic t_div;
      int w[6] = '{0, 200, 32, 256, 1024, 4096};
      for (int i = 1; i < 6; i++) begin
         wr(CNT_OFS, 8'h00);
         wr(CTRL_B_OFS, 8'(i));
         wt(w[i] - 2);
         wr(CTRL_B_OFS, 8'h00);
         rc(CNT_OFS, i == 1 ? 8'hc8 : 8'h04);
      end
   endtask : t_div
   task automatic t_ext(input tmr0_cs_t cs, input logic [4:0] n, input logic [7:0] exp);
      int k;
      wr(CNT_OFS, 8'h00);
      wr(CTRL_B_OFS, {5'h00, cs});
      @(posedge clk_sys_i);
      go <= 1'b1;
      tg <= n;
      @(posedge clk_sys_i);
      go <= 1'b0;
      @(negedge clk_sys_i);
      for (k = 0; k < 200 && !done; k++) @(negedge clk_sys_i);
      if (k == 200) begin
         mismatches++;
         close_out();
      end else begin
         wt(6);
         wr(CTRL_B_OFS, 8'h00);
         rc(CNT_OFS, exp);
      end
   endtask : t_ext
   task automatic t_match;
      wr(FLAGS_OFS, 8'hff);
      wr(CMP_A_OFS, 8'h05);
      wr(CMP_B_OFS, 8'h05);
      wr(MASK_OFS, 8'h18);
      global_irq_en_i <= 1'b1;
      wr(CNT_OFS, 8'h05);
      wr(CTRL_B_OFS, 8'h01);
      wt(8);
      wr(CTRL_B_OFS, 8'h00);
      rc(FLAGS_OFS, 8'h00);
      wr(CNT_OFS, 8'h03);
      wr(CTRL_B_OFS, 8'h01);
      wt(8);
      wr(CTRL_B_OFS, 8'h00);
      rc(FLAGS_OFS, 8'h18);
      pins(8'h0d);
      wt(1);
      global_irq_en_i <= 1'b0;
      wt(2);
      pins(8'h00);
      wt(1);
      global_irq_en_i <= 1'b1;
      wt(2);
      pins(8'h0d);
      pulse(0);
      rc(FLAGS_OFS, 8'h08);
      wr(FLAGS_OFS, 8'h08);
      rc(FLAGS_OFS, 8'h00);
      pins(8'h00);
      wr(CNT_OFS, 8'h04);
      wr(CTRL_B_OFS, 8'h01);
      wt(4);
      wr(CTRL_B_OFS, 8'h00);
      pulse(2);
      rc(FLAGS_OFS, 8'h10);
      wr(FCLR_OFS, 8'h10);
      rc(FLAGS_OFS, 8'h00);
   endtask : t_match
   task automatic t_ovf;
      wr(MASK_OFS, 8'h02);
      wr(CNT_OFS, 8'hfd);
      wr(CTRL_B_OFS, 8'h01);
      wt(4);
      wr(CTRL_B_OFS, 8'h00);
      rc(CNT_OFS, 8'h03);
      rc(FLAGS_OFS, 8'h02);
      pins(8'h03);
      pulse(1);
      rc(FLAGS_OFS, 8'h00);
      // phase correct with compare a as top: turns at 5, overflows at 0
      wr(CTRL_A_OFS, 8'h01);
      wr(CNT_OFS, 8'h02);
      wr(CTRL_B_OFS, 8'h09); // force bits zero while in pwm
      wt(8);
      wr(CTRL_B_OFS, 8'h00);
      rc(CNT_OFS, 8'h02);
      rc(FLAGS_OFS, 8'h1a);
      wr(FLAGS_OFS, 8'h1a);
   endtask : t_ovf
   task automatic t_force;
      wr(CTRL_A_OFS, 8'h70);
      wr(CTRL_B_OFS, 8'hc0);
      @(negedge clk_sys_i);
      chk({4'h0, wave_oe_a_o, wave_oe_b_o, wave_out_a_o, wave_out_b_o}, 8'h0f);
      rc(CTRL_B_OFS, 8'h00);
      rc(FLAGS_OFS, 8'h00);
      wr(CTRL_A_OFS, 8'hb1);
      // force in pwm on purpose, against the zero-write habit
      wr(CTRL_B_OFS, 8'h80);
      @(negedge clk_sys_i);
      chk({7'h0, wave_out_a_o}, 8'h01);
      wr(CTRL_A_OFS, 8'h00);
   endtask : t_force
   initial begin
      reset_n_i       = 1'b0;
      wr_i            = 1'b0;
      rd_i            = 1'b0;
      global_irq_en_i = 1'b0;
      ack_cmp_a_i     = 1'b0;
      ack_cmp_b_i     = 1'b0;
      ack_ovf_i       = 1'b0;
      go              = 1'b0;
      tg              = 5'h00;
      addr_i          = 6'h00;
      wdata_i         = 8'h00;
      mismatches      = 0;
      compares        = 0;
      wt(16);
      reset_n_i <= 1'b1;
      t_reset();
      t_div();
      t_ext(CS_EXT_FALL, 5'd9, 8'h04);
      t_ext(CS_EXT_RISE, 5'd7, 8'h03);
      t_match();
      t_ovf();
      t_force();
      close_out();
   end
endmodule : tb
`default_nettype wire
